// [icb_pkg.sv]
// shared constants and types for the interrupt and bank control block
package icb_pkg;
  // register byte offsets on the avalon slave
  localparam logic [6:0] ADDR_INSTR = 7'h00;
  localparam logic [6:0] ADDR_STATUS = 7'h04;
  localparam logic [6:0] ADDR_IO_ADDR = 7'h08;
  localparam logic [6:0] ADDR_PC = 7'h0c;
  localparam logic [6:0] ADDR_IDX_BASE = 7'h40;
  // status register field positions
  localparam int ST_INT_EN = 0;
  localparam int ST_ACK = 1;
  localparam int ST_INT_FF = 2;
  localparam int ST_HALT = 3;
  localparam int ST_STOP = 4;
  localparam int ST_BANK = 5;
  localparam int ST_ROM_BANK = 6;
  localparam int ST_PEND = 7;
  localparam int ST_ACC = 8;
  localparam int ST_SP = 12;
  // opcodes of the supplemental group
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_HALT = 8'h01;
  localparam logic [7:0] OP_RET_RESEND = 8'h02;
  localparam logic [7:0] OP_OR4 = 8'h04;
  localparam logic [7:0] OP_OR5 = 8'h05;
  localparam logic [7:0] OP_AN6 = 8'h06;
  localparam logic [7:0] OP_AN7 = 8'h07;
  localparam logic [7:0] OP_DB0 = 8'h08;
  localparam logic [7:0] OP_DB1 = 8'h09;
  localparam logic [7:0] OP_SB0 = 8'h0a;
  localparam logic [7:0] OP_SB1 = 8'h0b;
  localparam logic [7:0] OP_EIN = 8'h0c;
  localparam logic [7:0] OP_DIN = 8'h0d;
  // high nibbles of opcode groups
  localparam logic [3:0] HI_JCN = 4'h1;
  localparam logic [3:0] HI_FIM_SRC = 4'h2;
  localparam logic [3:0] HI_JIN = 4'h3;
  localparam logic [3:0] HI_JUN = 4'h4;
  localparam logic [3:0] HI_JMS = 4'h5;
  localparam logic [3:0] HI_ISZ = 4'h7;
  // forced call target: page 0, location 3
  localparam logic [11:0] FORCED_CALL_ADDR = 12'h003;
  // cycles between a designate instruction's end and the bank change
  localparam logic [1:0] ROM_BANK_DELAY = 2'h2;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [2:0] SP_RESET = 3'h0;
  localparam logic [3:0] ACC_RESET = 4'h0;
  localparam logic [7:0] IO_ADDR_RESET = 8'h00;

  typedef enum logic [2:0] {
    PH_A1, PH_A2, PH_A3, PH_M1, PH_M2, PH_X1, PH_X2, PH_X3
  } icb_phase_t;

  typedef struct packed {
    logic [7:0] operand;
    logic [7:0] opcode;
  } icb_instr_t;

  typedef struct packed {
    logic [1:0] rom_bank_select_line;
    logic ram_bank_select_line;
    logic [3:0] data;
    logic data_oe;
    logic data_in_block;
    logic int_ack;
    logic stop_ack;
  } icb_pins_t;
endpackage

// [icb_mem.sv]
// small synchronous memory with registered read data
module icb_mem #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic mclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata_q
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH > (1 << AW) || WIDTH < 1) begin : g_bad
    $error("icb_mem: depth does not fit the address width");
  end

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule

// [icb_core.sv]
// interrupt entry, return-and-resend, index and rom bank control
// What this block does
// - request caught into latch at memory_phase_two
// - interrupt flop sets at next single-cycle address_phase_one
// - following cycle holds pc, blocks input, calls 003
// - acknowledge flop sets at execute_phase_three
// - acknowledge holds until return; refuses new requests
// - twenty-four index registers, two lower banks, one upper
// - fixed-register instructions use selected lower bank
// - bank select saved on entry, restored on return
// - reset selects index bank zero
// - send_register_control fills eight-bit io address latch
// - io address latch frozen while acknowledge active
// - return restores pc, resends address, strobes selects
// - stack of eight twelve-bit entries
// - forced call pushes unincremented pc; return pops it
// - reset disables interrupts until enable instruction
// - enable and disable instructions gate interrupt detection
// - stop wins when both latched together
// - interrupt flop setting clears halt
// - two rom bank select outputs
// - designate bank takes effect third cycle later
// - designate bank instructions suppress interrupt recognition
// - opcodes 0c enable, 0d disable interrupts
// - opcode 02 is return_and_resend_io_address
// - opcodes 0a, 0b select index bank zero, one
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
module icb_core #(
  parameter int STACK_DEPTH = 8,
  parameter int IDX_REGS = 24
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic int_req_pin,
  input wire logic stop_pin,
  output icb_pkg::icb_pins_t pins
);
  if (STACK_DEPTH != 8 || IDX_REGS != 24) begin : g_bad
    $error("icb_core: stack and index sizes are fixed by the decode");
  end

  // maps a logical index register to its physical slot
  function automatic logic [4:0] idx_phys(input logic [3:0] n, input logic bank);
    if (n[3]) begin
      idx_phys = {2'b10, n[2:0]};
    end else begin
      idx_phys = {1'b0, bank, n[2:0]};
    end
  endfunction

  function automatic logic is_double(input logic [7:0] op);
    is_double = (op[7:4] == icb_pkg::HI_JCN) || (op[7:4] == icb_pkg::HI_JUN) ||
                (op[7:4] == icb_pkg::HI_JMS) || (op[7:4] == icb_pkg::HI_ISZ) ||
                (op[7:4] == icb_pkg::HI_FIM_SRC && !op[0]);
  endfunction

  icb_pkg::icb_phase_t ph_q, ph_d;
  icb_pkg::icb_instr_t cur_q, cur_d, pend_q, pend_d;
  icb_pkg::icb_pins_t pins_q, pins_d;
  logic pend_v_q, pend_v_d, dbl_q, dbl_d, exec_q, exec_d, forced_q, forced_d;
  logic [11:0] pc_q, pc_d;
  logic [2:0] sp_q, sp_d;
  logic [3:0] acc_q, acc_d;
  logic int_en_q, int_en_d, int_latch_q, int_latch_d, stop_latch_q, stop_latch_d;
  logic int_ff_q, int_ff_d, ack_q, ack_d, halt_q, halt_d, stop_ff_q, stop_ff_d;
  logic bank_q, bank_d, bank_saved_q, bank_saved_d;
  logic [7:0] io_addr_q, io_addr_d;
  logic cr3_q, cr3_d, rom_bank_q, rom_bank_d;
  logic [1:0] db_cnt_q, db_cnt_d;
  logic int_s1_q, int_s2_q, stop_s1_q, stop_s2_q;
  logic wait_q, wait_d, idx_pend_q, idx_pend_d;
  logic [31:0] rdata_q, rdata_d;
  logic stk_we, idx_we;
  logic [2:0] stk_waddr, stk_raddr;
  logic [11:0] stk_wdata, stk_rdata;
  logic [4:0] idx_waddr, idx_raddr;
  logic [3:0] idx_wdata, idx_rdata;
  logic [7:0] op;
  logic is_db, port_busy, bus_req, bus_idx;

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign pins = pins_q;

  icb_mem #(.WIDTH(12), .DEPTH(STACK_DEPTH), .AW(3)) u_stack (
    .mclk(mclk),
    .we(stk_we),
    .waddr(stk_waddr),
    .wdata(stk_wdata),
    .raddr(stk_raddr),
    .rdata_q(stk_rdata)
  );

  icb_mem #(.WIDTH(4), .DEPTH(IDX_REGS), .AW(5)) u_index (
    .mclk(mclk),
    .we(idx_we),
    .waddr(idx_waddr),
    .wdata(idx_wdata),
    .raddr(idx_raddr),
    .rdata_q(idx_rdata)
  );

  // pins are asynchronous; only the second stage is read
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      int_s1_q <= 1'b0;
      int_s2_q <= 1'b0;
      stop_s1_q <= 1'b0;
      stop_s2_q <= 1'b0;
    end else begin
      int_s1_q <= int_req_pin;
      int_s2_q <= int_s1_q;
      stop_s1_q <= stop_pin;
      stop_s2_q <= stop_s1_q;
    end
  end

  assign op = cur_q.opcode;
  assign is_db = exec_q && (op == icb_pkg::OP_DB0 || op == icb_pkg::OP_DB1);
  // the index port belongs to the instruction at memory_phase_two and X1
  assign port_busy = (ph_q == icb_pkg::PH_M2) || (ph_q == icb_pkg::PH_X1);
  assign bus_req = avs_read || avs_write;
  assign bus_idx = avs_address >= icb_pkg::ADDR_IDX_BASE;

  always_comb begin
    ph_d = (ph_q == icb_pkg::PH_X3) ? icb_pkg::PH_A1 : icb_pkg::icb_phase_t'(ph_q + 3'h1);
    cur_d = cur_q;
    pend_d = pend_q;
    pend_v_d = pend_v_q;
    dbl_d = dbl_q;
    exec_d = exec_q;
    forced_d = forced_q;
    pc_d = pc_q;
    sp_d = sp_q;
    acc_d = acc_q;
    int_en_d = int_en_q;
    int_latch_d = int_latch_q;
    stop_latch_d = stop_latch_q;
    int_ff_d = int_ff_q;
    ack_d = ack_q;
    halt_d = halt_q;
    stop_ff_d = stop_ff_q;
    bank_d = bank_q;
    bank_saved_d = bank_saved_q;
    io_addr_d = io_addr_q;
    cr3_d = cr3_q;
    rom_bank_d = rom_bank_q;
    db_cnt_d = db_cnt_q;
    pins_d = pins_q;
    pins_d.ram_bank_select_line = 1'b0;
    pins_d.rom_bank_select_line = 2'b00;
    pins_d.data_oe = 1'b0;
    pins_d.data = 4'h0;
    stk_we = 1'b0;
    stk_waddr = sp_q;
    stk_wdata = pc_q;
    stk_raddr = sp_q - 3'h1;
    idx_we = 1'b0;
    idx_waddr = 5'h00;
    idx_wdata = 4'h0;
    idx_raddr = idx_phys(avs_address[5:2], 1'b0);
    wait_d = 1'b1;
    idx_pend_d = idx_pend_q;
    rdata_d = rdata_q;

    unique case (ph_q)
      icb_pkg::PH_A1: begin
        if (dbl_q) begin
          dbl_d = 1'b0;
        end else begin
          forced_d = 1'b0;
          exec_d = 1'b0;
          cur_d.opcode = icb_pkg::OP_NOP;
          if (stop_latch_q) begin
            stop_ff_d = 1'b1;
            halt_d = 1'b0;
          end
          if (int_ff_q) begin
            // forced call to 0,3: pc frozen, bus input blocked
            int_ff_d = 1'b0;
            forced_d = 1'b1;
            cur_d.opcode = {icb_pkg::HI_JMS, 4'h0};
          end else if (stop_latch_q || stop_ff_q || halt_q) begin
            cur_d.opcode = icb_pkg::OP_NOP;
          end else if (pend_v_q) begin
            cur_d = pend_q;
            pend_v_d = 1'b0;
            exec_d = 1'b1;
            dbl_d = is_double(pend_q.opcode);
          end
          // stop holds priority; halt still lets the interrupt in
          if (int_latch_q && !stop_latch_q && !(stop_ff_q && !halt_q) && !int_ff_q) begin
            int_ff_d = 1'b1;
            int_latch_d = 1'b0;
            halt_d = 1'b0;
          end
        end
      end
      icb_pkg::PH_A3: begin
        pins_d.rom_bank_select_line = rom_bank_q ? 2'b10 : 2'b01;
      end
      icb_pkg::PH_M2: begin
        stop_latch_d = stop_s2_q;
        // refused while acknowledged, disabled, or a bank switch runs
        if (int_s2_q && int_en_q && !ack_q && !int_ff_q && !forced_q &&
            !is_db && db_cnt_q == 2'h0) begin
          int_latch_d = 1'b1;
        end
        if (op[7:4] == icb_pkg::HI_JIN && !op[0]) begin
          idx_raddr = idx_phys({op[3:1], 1'b0}, bank_q);
        end else begin
          idx_raddr = idx_phys(op[3:0], bank_q);
        end
      end
      icb_pkg::PH_X1: begin
        idx_raddr = idx_phys({op[3:1], 1'b1}, bank_q);
        if (exec_q && !dbl_q) begin
          unique case (op)
            icb_pkg::OP_OR4, icb_pkg::OP_OR5: acc_d = acc_q | idx_rdata;
            icb_pkg::OP_AN6, icb_pkg::OP_AN7: acc_d = acc_q & idx_rdata;
            default: acc_d = acc_q;
          endcase
          if (op[7:4] == icb_pkg::HI_JIN && !op[0]) begin
            pc_d = {pc_q[11:8], idx_rdata, pc_q[3:0]};
          end
        end
      end
      icb_pkg::PH_X2: begin
        if (exec_q && op[7:4] == icb_pkg::HI_JIN && !op[0]) begin
          pc_d = {pc_q[11:4], idx_rdata};
        end
        if (exec_q && op[7:4] == icb_pkg::HI_FIM_SRC && op[0]) begin
          pins_d.data = cur_q.operand[7:4];
          pins_d.data_oe = 1'b1;
          pins_d.ram_bank_select_line = 1'b1;
          pins_d.rom_bank_select_line = rom_bank_q ? 2'b10 : 2'b01;
          if (!ack_q) begin
            io_addr_d[7:4] = cur_q.operand[7:4];
          end
        end
        if (exec_q && op == icb_pkg::OP_RET_RESEND) begin
          pc_d = stk_rdata;
          pins_d.data = io_addr_q[7:4];
          pins_d.data_oe = 1'b1;
          pins_d.ram_bank_select_line = 1'b1;
          pins_d.rom_bank_select_line = rom_bank_q ? 2'b10 : 2'b01;
        end
      end
      icb_pkg::PH_X3: begin
        if (!stop_latch_q && !halt_q) begin
          stop_ff_d = 1'b0;
        end
        if (db_cnt_q != 2'h0) begin
          db_cnt_d = db_cnt_q - 2'h1;
          if (db_cnt_q == 2'h1) begin
            rom_bank_d = cr3_q;
          end
        end
        if (forced_q) begin
          ack_d = 1'b1;
          stk_we = 1'b1;
          sp_d = sp_q + 3'h1;
          pc_d = icb_pkg::FORCED_CALL_ADDR;
          bank_saved_d = bank_q;
        end else if (exec_q && !dbl_q) begin
          pc_d = pc_q + 12'h001;
          unique case (op)
            icb_pkg::OP_HALT: begin
              halt_d = 1'b1;
              stop_ff_d = 1'b1;
            end
            icb_pkg::OP_RET_RESEND: begin
              pc_d = pc_q;
              sp_d = sp_q - 3'h1;
              ack_d = 1'b0;
              bank_d = bank_saved_q;
              pins_d.data = io_addr_q[3:0];
              pins_d.data_oe = 1'b1;
            end
            icb_pkg::OP_DB0, icb_pkg::OP_DB1: begin
              cr3_d = op[0];
              db_cnt_d = icb_pkg::ROM_BANK_DELAY;
            end
            icb_pkg::OP_SB0: bank_d = 1'b0;
            icb_pkg::OP_SB1: bank_d = 1'b1;
            icb_pkg::OP_EIN: int_en_d = 1'b1;
            icb_pkg::OP_DIN: int_en_d = 1'b0;
            default: begin
              if (op[7:4] == icb_pkg::HI_FIM_SRC && op[0]) begin
                pins_d.data = cur_q.operand[3:0];
                pins_d.data_oe = 1'b1;
                if (!ack_q) begin
                  io_addr_d[3:0] = cur_q.operand[3:0];
                end
              end
              if (op[7:4] == icb_pkg::HI_JIN && !op[0]) begin
                pc_d = pc_q;
              end
            end
          endcase
        end else if (exec_q && dbl_q) begin
          pc_d = pc_q + 12'h002;
          if (op[7:4] == icb_pkg::HI_JUN) begin
            pc_d = {op[3:0], cur_q.operand};
          end
          if (op[7:4] == icb_pkg::HI_JMS) begin
            stk_we = 1'b1;
            stk_wdata = pc_q + 12'h002;
            sp_d = sp_q + 3'h1;
            pc_d = {op[3:0], cur_q.operand};
          end
        end
      end
      default: begin
        cur_d = cur_q;
      end
    endcase

    pins_d.int_ack = ack_d;
    pins_d.stop_ack = stop_ff_d;
    pins_d.data_in_block = forced_d || stop_ff_d || halt_d;

    // bus slave: one answer cycle with waitrequest low
    if (bus_req && wait_q) begin
      if (bus_idx) begin
        if (avs_write) begin
          if (!port_busy) begin
            idx_we = 1'b1;
            idx_waddr = idx_phys(avs_address[5:2], bank_q);
            idx_wdata = avs_writedata[3:0];
            wait_d = 1'b0;
          end
        end else if (idx_pend_q) begin
          idx_pend_d = 1'b0;
          rdata_d = {28'h0000000, idx_rdata};
          wait_d = 1'b0;
        end else if (!port_busy) begin
          idx_raddr = idx_phys(avs_address[5:2], bank_q);
          idx_pend_d = 1'b1;
        end
      end else begin
        wait_d = 1'b0;
        rdata_d = 32'h00000000;
        unique case (avs_address)
          icb_pkg::ADDR_INSTR: begin
            if (avs_write) begin
              // a second instruction waits until the first is taken
              if (pend_v_q) begin
                wait_d = 1'b1;
              end else begin
                pend_d = avs_writedata[15:0];
                pend_v_d = 1'b1;
              end
            end
          end
          icb_pkg::ADDR_STATUS: begin
            rdata_d[icb_pkg::ST_INT_EN] = int_en_q;
            rdata_d[icb_pkg::ST_ACK] = ack_q;
            rdata_d[icb_pkg::ST_INT_FF] = int_ff_q;
            rdata_d[icb_pkg::ST_HALT] = halt_q;
            rdata_d[icb_pkg::ST_STOP] = stop_ff_q;
            rdata_d[icb_pkg::ST_BANK] = bank_q;
            rdata_d[icb_pkg::ST_ROM_BANK] = rom_bank_q;
            rdata_d[icb_pkg::ST_PEND] = pend_v_q;
            rdata_d[icb_pkg::ST_ACC +: 4] = acc_q;
            rdata_d[icb_pkg::ST_SP +: 3] = sp_q;
          end
          icb_pkg::ADDR_IO_ADDR: rdata_d[7:0] = io_addr_q;
          icb_pkg::ADDR_PC: rdata_d[11:0] = pc_q;
          default: rdata_d = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ph_q <= icb_pkg::PH_A1;
      cur_q <= '0;
      pend_q <= '0;
      pend_v_q <= 1'b0;
      dbl_q <= 1'b0;
      exec_q <= 1'b0;
      forced_q <= 1'b0;
      pc_q <= icb_pkg::PC_RESET;
      sp_q <= icb_pkg::SP_RESET;
      acc_q <= icb_pkg::ACC_RESET;
      int_en_q <= 1'b0;
      int_latch_q <= 1'b0;
      stop_latch_q <= 1'b0;
      int_ff_q <= 1'b0;
      ack_q <= 1'b0;
      halt_q <= 1'b0;
      stop_ff_q <= 1'b0;
      bank_q <= 1'b0;
      bank_saved_q <= 1'b0;
      io_addr_q <= icb_pkg::IO_ADDR_RESET;
      cr3_q <= 1'b0;
      rom_bank_q <= 1'b0;
      db_cnt_q <= 2'h0;
      pins_q <= '0;
      wait_q <= 1'b1;
      idx_pend_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ph_q <= ph_d;
      cur_q <= cur_d;
      pend_q <= pend_d;
      pend_v_q <= pend_v_d;
      dbl_q <= dbl_d;
      exec_q <= exec_d;
      forced_q <= forced_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      acc_q <= acc_d;
      int_en_q <= int_en_d;
      int_latch_q <= int_latch_d;
      stop_latch_q <= stop_latch_d;
      int_ff_q <= int_ff_d;
      ack_q <= ack_d;
      halt_q <= halt_d;
      stop_ff_q <= stop_ff_d;
      bank_q <= bank_d;
      bank_saved_q <= bank_saved_d;
      io_addr_q <= io_addr_d;
      cr3_q <= cr3_d;
      rom_bank_q <= rom_bank_d;
      db_cnt_q <= db_cnt_d;
      pins_q <= pins_d;
      wait_q <= wait_d;
      idx_pend_q <= idx_pend_d;
      rdata_q <= rdata_d;
    end
  end
endmodule

// [icb_core_sva.sv]
// port-level assertions for the interrupt and bank control block
module icb_core_sva (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic int_req_pin,
  input wire icb_pkg::icb_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  sequence rom_pulse_s;
    $onehot(pins.rom_bank_select_line) ##1 pins.rom_bank_select_line == 2'h0;
  endsequence
  sequence resend_s;
    pins.data_oe ##1 pins.data_oe;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> pins == '0)
    else $error("pins not cleared by reset");
  a_rom_pulse_once: assert property (|pins.rom_bank_select_line |-> rom_pulse_s)
    else $error("rom select not a single one-hot pulse");
  a_rom_every_cycle: assert property (
    |pins.rom_bank_select_line |-> ##[1:8] |pins.rom_bank_select_line)
    else $error("rom select pulse missing in a cycle");
  a_ram_with_rom: assert property (
    pins.ram_bank_select_line |-> |pins.rom_bank_select_line)
    else $error("ram select without rom select");
  a_resend_nibbles: assert property (pins.ram_bank_select_line |-> resend_s)
    else $error("address nibbles not driven for two phases");
  a_ack_until_return: assert property (
    $fell(pins.int_ack) |-> $past(pins.ram_bank_select_line) ||
      $past(pins.ram_bank_select_line, 2))
    else $error("acknowledge dropped without a return");
  a_ack_has_cause: assert property (
    $rose(pins.int_ack) |-> $past(int_req_pin) && !pins.stop_ack)
    else $error("acknowledge without request or during stop");
  a_ack_after_block: assert property (
    $rose(pins.int_ack) |-> $past(pins.data_in_block))
    else $error("acknowledge without a blocked forced call");
endmodule

// [icb_irq_src.sv]
// interrupt source model: raises its request and holds it until acknowledged or cancelled
module icb_irq_src (
  input wire logic mclk,
  input wire logic fire,
  input wire logic cancel,
  input wire logic int_ack,
  output logic int_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ack_q = 1'b0;
  initial int_req = 1'b0;
  // drops only on cancel or a fresh acknowledge, so a request made inside the handler stays up
  always @(posedge mclk) begin
    ack_q <= int_ack;
    if (fire)
      int_req <= 1'b1;
    else if (cancel || (int_ack && !ack_q))
      int_req <= 1'b0;
  end
endmodule

// [cpu_interrupt_bank_control_tb.sv]
// self-checking bench for the interrupt and bank control block
module cpu_interrupt_bank_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] A_ST = icb_pkg::ADDR_STATUS;
  localparam logic [6:0] A_PC = icb_pkg::ADDR_PC;
  localparam logic [6:0] A_IO = icb_pkg::ADDR_IO_ADDR;
  logic mclk, rstn, avs_read, avs_write, avs_waitrequest, stop_pin, fire, cancel, int_req;
  logic [6:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [11:0] pc0;
  icb_pkg::icb_pins_t pins;
  int miscompares = 0;
  int comparisons = 0;
  icb_core dut_u (
    .mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .int_req_pin(int_req), .stop_pin(stop_pin), .pins(pins)
  );
  icb_irq_src src_u (
    .mclk(mclk), .fire(fire), .cancel(cancel), .int_ack(pins.int_ack), .int_req(int_req)
  );
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic tally_and_finish();
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    if (!wr)
      rd = avs_readdata;
    if (n >= 100)
      chk("bus_answer", 32'h0, 32'h1);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic exec(input logic [7:0] op, input logic [7:0] opd);
    int n;
    n = 0;
    bus(1'b1, icb_pkg::ADDR_INSTR, {16'h0, opd, op});
    rd = '1;
    while (rd[icb_pkg::ST_PEND] !== 1'b0 && n < 30) begin
      bus(1'b0, A_ST, 32'h0);
      n++;
    end
    // taken at address_phase_one only; let it run to its last phase, double ones too
    repeat (16) @(posedge mclk);
  endtask
  task automatic st(input string w, input int b, input logic e);
    bus(1'b0, A_ST, 32'h0);
    chk(w, {31'h0, e}, {31'h0, rd[b]});
  endtask
  task automatic wait_ack(input logic v, output int n);
    n = 0;
    while (pins.int_ack !== v && n < 300) begin
      @(posedge mclk);
      n++;
    end
    chk("int_ack", {31'h0, v}, {31'h0, pins.int_ack});
  endtask
  task automatic pulse();
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
  endtask
  task automatic ret();
    int n;
    exec(icb_pkg::OP_RET_RESEND, 8'h0);
    wait_ack(1'b0, n);
  endtask
  task automatic t_reset();
    bus(1'b0, A_ST, 32'h0);
    chk("status", 32'h0, rd & 32'h7fff);
    bus(1'b0, A_PC, 32'h0);
    chk("pc", 32'h0, rd);
    bus(1'b1, 7'h30, 32'hffff);
    bus(1'b0, 7'h30, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic t_banks();
    bus(1'b1, 7'h50, 32'h5);
    bus(1'b1, 7'h60, 32'h3);
    exec(icb_pkg::OP_SB1, 8'h0);
    bus(1'b1, 7'h50, 32'ha);
    exec(icb_pkg::OP_OR4, 8'h0);
    bus(1'b0, A_ST, 32'h0);
    chk("acc", 32'ha, (rd >> icb_pkg::ST_ACC) & 32'hf);
    bus(1'b0, 7'h60, 32'h0);
    chk("upper_reg", 32'h3, rd);
    exec(icb_pkg::OP_SB0, 8'h0);
    bus(1'b0, 7'h50, 32'h0);
    chk("lower_reg", 32'h5, rd);
  endtask
  task automatic t_irq();
    int n;
    exec(8'h21, 8'h5a);
    bus(1'b0, A_IO, 32'h0);
    chk("io_addr", 32'h5a, rd);
    exec(icb_pkg::OP_SB1, 8'h0);
    pulse();
    repeat (40) @(posedge mclk);
    chk("int_ack", 32'h0, {31'h0, pins.int_ack});
    cancel <= 1'b1;
    @(posedge mclk);
    cancel <= 1'b0;
    exec(icb_pkg::OP_EIN, 8'h0);
    repeat (16) @(posedge mclk);
    bus(1'b0, A_PC, 32'h0);
    pc0 = rd[11:0];
    pulse();
    wait_ack(1'b1, n);
    bus(1'b0, A_PC, 32'h0);
    chk("pc", 32'h3, rd);
    bus(1'b0, A_ST, 32'h0);
    chk("sp", 32'h1, (rd >> icb_pkg::ST_SP) & 32'h7);
    exec(8'h21, 8'hc3);
    bus(1'b0, A_IO, 32'h0);
    chk("io_addr", 32'h5a, rd);
    exec(icb_pkg::OP_SB0, 8'h0);
    pulse();
    repeat (40) @(posedge mclk);
    st("int_ff", icb_pkg::ST_INT_FF, 1'b0);
    exec(icb_pkg::OP_DIN, 8'h0);
    bus(1'b1, icb_pkg::ADDR_INSTR, {24'h0, icb_pkg::OP_RET_RESEND});
    n = 0;
    while (pins.ram_bank_select_line !== 1'b1 && n < 60) begin
      @(posedge mclk);
      n++;
    end
    chk("hi_nibble", 32'h5, {28'h0, pins.data});
    @(posedge mclk);
    chk("lo_nibble", 32'ha, {28'h0, pins.data});
    wait_ack(1'b0, n);
    bus(1'b0, A_PC, 32'h0);
    chk("pc", {20'h0, pc0}, rd);
    bus(1'b0, A_ST, 32'h0);
    chk("status", 32'h20, rd & 32'h7027);
    cancel <= 1'b1;
    @(posedge mclk);
    cancel <= 1'b0;
    exec(icb_pkg::OP_SB0, 8'h0);
  endtask
  task automatic t_rom();
    int n;
    exec(icb_pkg::OP_EIN, 8'h0);
    // raw write: the request must rise while the bank switch still runs
    bus(1'b1, icb_pkg::ADDR_INSTR, {24'h0, icb_pkg::OP_DB1});
    st("rom_bank", icb_pkg::ST_ROM_BANK, 1'b0);
    pulse();
    wait_ack(1'b1, n);
    // unsuppressed entry acks within 30 cycles, suppressed not before 43
    chk("entry_late", 32'h1, {31'h0, n > 38});
    st("rom_bank", icb_pkg::ST_ROM_BANK, 1'b1);
    n = 0;
    while (pins.rom_bank_select_line === 2'h0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    chk("rom_line", 32'h2, {30'h0, pins.rom_bank_select_line});
    ret();
  endtask
  task automatic t_halt();
    int n;
    exec(icb_pkg::OP_HALT, 8'h0);
    repeat (10) @(posedge mclk);
    st("halt", icb_pkg::ST_HALT, 1'b1);
    pulse();
    wait_ack(1'b1, n);
    st("halt", icb_pkg::ST_HALT, 1'b0);
    ret();
  endtask
  task automatic t_stop();
    int n;
    stop_pin <= 1'b1;
    pulse();
    n = 0;
    while (pins.stop_ack !== 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    chk("stop_ack", 32'h1, {31'h0, pins.stop_ack});
    repeat (40) @(posedge mclk);
    chk("int_ack", 32'h0, {31'h0, pins.int_ack});
    stop_pin <= 1'b0;
    wait_ack(1'b1, n);
    ret();
  endtask
  initial begin
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 7'h0;
    avs_writedata = 32'h0;
    stop_pin = 1'b0;
    fire = 1'b0;
    cancel = 1'b0;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_banks();
    t_irq();
    t_rom();
    t_halt();
    t_stop();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    tally_and_finish();
  end
endmodule

bind icb_core icb_core_sva chk_u (
  .mclk(mclk), .rstn(rstn), .int_req_pin(int_req_pin), .pins(pins)
);
